// [vpiu_cfg.svh]
`ifndef VPIU_CFG_SVH
`define VPIU_CFG_SVH
// vector table geometry
`define VPIU_NUM_VEC 46
`define VPIU_VEC_W 6
`define VPIU_ADDR_W 21
`define VPIU_ENTRY_W 19
`define VPIU_BASE_RST 21'h000000
// vector number ranges
`define VPIU_VEC_RESET 6'h00
`define VPIU_VEC_WDOG 6'h01
`define VPIU_CORE_LO 2
`define VPIU_CORE_HI 5
`define VPIU_DBG_LO 6
`define VPIU_DBG_HI 10
`define VPIU_SWI2 11
`define VPIU_SWI1 12
`define VPIU_SWI0 13
`define VPIU_PER_LO 16
`define VPIU_PER_HI 44
`define VPIU_VEC_CLKSYN 17
`define VPIU_VEC_CONV_A 40
`define VPIU_VEC_CONV_B 41
`define VPIU_VEC_CONV_ERR 42
`define VPIU_VEC_LOWSW 45
// encoded ranks: rank = level + 1, rank 0 is the lowest software request
`define VPIU_RANK_LOW 3'h0
`define VPIU_RANK_L0 3'h1
`define VPIU_RANK_L1 3'h2
`define VPIU_RANK_L2 3'h3
`define VPIU_RANK_L3 3'h4
`endif

// [vpiu_pkg.sv]
package vpiu_pkg;
	typedef logic [2:0] vpiu_rank_t;
	typedef logic [5:0] vpiu_vec_t;
	typedef enum logic [1:0] {
		VPIU_LVL0,
		VPIU_LVL1,
		VPIU_LVL2,
		VPIU_LVL3
	} vpiu_level_t;
endpackage

// [vpiu_pick.sv]
`include "vpiu_cfg.svh"
// picks the better of two candidates: higher rank, then smaller vector
module vpiu_pick
	import vpiu_pkg::*;
(
	// candidate a (always the smaller vector side)
	input wire logic a_vld,
	input wire vpiu_rank_t a_rank,
	input wire vpiu_vec_t a_vec,
	// candidate b
	input wire logic b_vld,
	input wire vpiu_rank_t b_rank,
	input wire vpiu_vec_t b_vec,
	// winner
	output logic o_vld,
	output vpiu_rank_t o_rank,
	output vpiu_vec_t o_vec
);
	logic take_b;

	// ties go to a, which holds the smaller vector numbers
	assign take_b = b_vld && (!a_vld || (b_rank > a_rank));
	assign o_vld = a_vld || b_vld;
	assign o_rank = take_b ? b_rank : a_rank;
	assign o_vec = take_b ? b_vec : a_vec;
endmodule

// [vpiu_top.sv]
`include "vpiu_cfg.svh"
module vpiu_top
	import vpiu_pkg::*;
#(
	parameter int NUM_VEC = `VPIU_NUM_VEC
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// core exception and software requests, one-cycle pulses
	input wire logic [NUM_VEC-1:0] req_pulse,
	// level-held sources, withdrawn by dropping the level
	input wire logic [NUM_VEC-1:0] req_level,
	// converter requests
	input wire logic conv_a_done,
	input wire logic conv_b_done,
	input wire logic conv_zero_cross,
	input wire logic conv_limit_err,
	// programmed levels, two bits per vector
	input wire logic [2*NUM_VEC-1:0] level_cfg,
	// vector base, word address
	input wire logic [`VPIU_ADDR_W-1:0] vector_base_register,
	input wire logic base_wr,
	// core side
	input wire logic irq_ack,
	output logic irq_valid,
	output vpiu_vec_t irq_vec,
	output logic [`VPIU_ADDR_W-1:0] irq_addr,
	output logic [`VPIU_ADDR_W-1:0] reset_addr,
	output logic [`VPIU_ADDR_W-1:0] wdog_addr
);
	logic [NUM_VEC-1:0] pend_r;
	logic [NUM_VEC-1:0] src;
	logic [`VPIU_ADDR_W-1:0] base_r;
	logic irq_valid_r;
	vpiu_vec_t irq_vec_r;
	logic [`VPIU_ADDR_W-1:0] irq_addr_r;
	logic [`VPIU_ADDR_W-1:0] irq_addr_nxt;
	vpiu_rank_t rank [NUM_VEC];
	logic [NUM_VEC-1:0] cand;
	logic [NUM_VEC-1:0] ack_hit;
	logic [NUM_VEC-1:0] lat_r;
	logic [NUM_VEC-1:0] lat_nxt;

	// converter sources folded onto their three vectors
	always_comb begin
		src = req_level;
		src[`VPIU_VEC_CONV_A] = req_level[`VPIU_VEC_CONV_A] | conv_a_done;
		src[`VPIU_VEC_CONV_B] = req_level[`VPIU_VEC_CONV_B] | conv_b_done;
		src[`VPIU_VEC_CONV_ERR] = req_level[`VPIU_VEC_CONV_ERR] |
			conv_zero_cross | conv_limit_err;
	end

	// rank of each vector from its fixed or programmed level
	always_comb begin
		for (int v = 0; v < NUM_VEC; v++) begin
			logic [1:0] lv;
			lv = level_cfg[2*v +: 2];
			if (v >= `VPIU_CORE_LO && v <= `VPIU_CORE_HI)
				rank[v] = `VPIU_RANK_L3;
			else if (v >= `VPIU_DBG_LO && v <= `VPIU_DBG_HI)
				rank[v] = (lv == 2'h0) ? `VPIU_RANK_L1 : 3'(lv) + 3'h1;
			else if (v == `VPIU_SWI2)
				rank[v] = `VPIU_RANK_L2;
			else if (v == `VPIU_SWI1)
				rank[v] = `VPIU_RANK_L1;
			else if (v >= `VPIU_PER_LO && v <= `VPIU_PER_HI)
				rank[v] = (lv == 2'h3) ? `VPIU_RANK_L2 : 3'(lv) + 3'h1;
			else if (v == `VPIU_VEC_LOWSW)
				rank[v] = `VPIU_RANK_LOW;
			else
				rank[v] = `VPIU_RANK_L0;
		end
	end

	// entries 0/1 and the reserved holes never compete
	always_comb begin
		cand = pend_r;
		cand[0] = 1'b0;
		cand[1] = 1'b0;
		cand[14] = 1'b0;
		cand[15] = 1'b0;
		cand[21] = 1'b0;
		cand[33] = 1'b0;
		cand[34] = 1'b0;
	end

	// binary tournament built from two-input pickers
	localparam int LEAVES = 64;
	logic t_vld [2*LEAVES-1];
	vpiu_rank_t t_rank [2*LEAVES-1];
	vpiu_vec_t t_vec [2*LEAVES-1];

	genvar g;
	generate
		for (g = 0; g < LEAVES; g++) begin : g_leaf
			if (g < NUM_VEC) begin : g_real
				assign t_vld[LEAVES-1+g] = cand[g];
				assign t_rank[LEAVES-1+g] = rank[g];
			end else begin : g_pad
				assign t_vld[LEAVES-1+g] = 1'b0;
				assign t_rank[LEAVES-1+g] = `VPIU_RANK_LOW;
			end
			assign t_vec[LEAVES-1+g] = 6'(g);
		end
		for (g = 0; g < LEAVES-1; g++) begin : g_node
			vpiu_pick u_pick (
				.a_vld(t_vld[2*g+1]),
				.a_rank(t_rank[2*g+1]),
				.a_vec(t_vec[2*g+1]),
				.b_vld(t_vld[2*g+2]),
				.b_rank(t_rank[2*g+2]),
				.b_vec(t_vec[2*g+2]),
				.o_vld(t_vld[g]),
				.o_rank(t_rank[g]),
				.o_vec(t_vec[g])
			);
		end
	endgenerate

	// acknowledge clears the vector that is being presented
	always_comb begin
		ack_hit = '0;
		if (irq_ack && irq_valid_r)
			ack_hit[irq_vec_r] = 1'b1;
	end

	// pulses are remembered until acked; a new pulse beats a same-cycle ack
	assign lat_nxt = (lat_r & ~ack_hit) | req_pulse;

	// levels are copied fresh each cycle, so dropping one withdraws it;
	// a level still high after its ack is simply offered again
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lat_r <= '0;
			pend_r <= '0;
		end else begin
			lat_r <= lat_nxt;
			pend_r <= lat_nxt | src;
		end
	end

	// vector base, zero after reset so entries 0/1 overlay reset vectors
	always_ff @(posedge mclk) begin
		if (!nrst)
			base_r <= `VPIU_BASE_RST;
		else if (base_wr)
			base_r <= vector_base_register;
	end

	// offset is twice the vector; it cannot exceed the 19-bit reach
	assign irq_addr_nxt = base_r + `VPIU_ADDR_W'({t_vec[0], 1'b0});

	// winner registered every cycle; ack of the shown vector drops it unless a fresh pulse or a held level renews it
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_valid_r <= 1'b0;
			irq_vec_r <= '0;
			irq_addr_r <= '0;
		end else begin
			irq_valid_r <= t_vld[0] && !(ack_hit[t_vec[0]] && !req_pulse[t_vec[0]]
				&& !src[t_vec[0]]);
			irq_vec_r <= t_vec[0];
			irq_addr_r <= irq_addr_nxt;
		end
	end

	assign irq_valid = irq_valid_r;
	assign irq_vec = irq_vec_r;
	assign irq_addr = irq_addr_r;
	// reset fetches land on entries 0 and 1 of the table
	assign reset_addr = base_r + `VPIU_ADDR_W'({`VPIU_VEC_RESET, 1'b0});
	assign wdog_addr = base_r + `VPIU_ADDR_W'({`VPIU_VEC_WDOG, 1'b0});

	// ---- checks ----
	logic any_top;
	logic better_seen;
	logic [NUM_VEC-1:0] others;

	// independent scan of all competitors, so a broken picker tree or a
	// bad tie rule shows up instead of agreeing with itself
	always_comb begin
		any_top = 1'b0;
		better_seen = 1'b0;
		for (int v = 0; v < NUM_VEC; v++) begin
			if (cand[v] && rank[v] == `VPIU_RANK_L3)
				any_top = 1'b1;
			if (cand[v] && t_vld[0] && (rank[v] > t_rank[0] ||
				(rank[v] == t_rank[0] && 6'(v) < t_vec[0])))
				better_seen = 1'b1;
		end
	end

	// every competitor except the lowest software request
	always_comb begin
		others = cand;
		others[`VPIU_VEC_LOWSW] = 1'b0;
	end

	sequence s_pick;
		irq_valid_r;
	endsequence

	// a fresh core exception pulse, nothing of its kind pending yet
	sequence s_core_pulse;
		req_pulse[`VPIU_CORE_LO] && !pend_r[`VPIU_CORE_LO];
	endsequence

	// latched at the first edge, offered to the core one edge later
	sequence s_core_offer;
		lat_r[`VPIU_CORE_LO] ##1
		(irq_valid_r && irq_vec_r == 6'(`VPIU_CORE_LO));
	endsequence

	// reset overlays never leave as interrupts
	AST_NO_RESET_VEC: assert property (
		@(posedge mclk) disable iff (!nrst)
		irq_valid_r |-> irq_vec_r > 6'h01)
		else $error("reset entry issued as interrupt");

	// reserved holes in the table never leave either
	AST_NO_HOLE: assert property (
		@(posedge mclk) disable iff (!nrst)
		irq_valid_r |-> !(irq_vec_r inside {6'h0E, 6'h0F, 6'h15, 6'h21,
		6'h22}))
		else $error("reserved entry issued as interrupt");

	// the address was formed from the base of the cycle before
	AST_ADDR_SUM: assert property (
		@(posedge mclk) disable iff (!nrst)
		s_pick |-> irq_addr_r ==
		$past(base_r) + `VPIU_ADDR_W'({irq_vec_r, 1'b0}))
		else $error("vector address mismatch");

	// a written base is the one used from the next edge on
	AST_BASE_LOAD: assert property (
		@(posedge mclk) disable iff (!nrst)
		base_wr |=> base_r == $past(vector_base_register))
		else $error("vector base not loaded");

	// any level 3 request keeps lower levels out
	AST_RANK_TOP: assert property (
		@(posedge mclk) disable iff (!nrst)
		any_top |-> t_vld[0] && t_rank[0] == `VPIU_RANK_L3)
		else $error("winner below a pending level 3 request");

	// nobody pending beats the winner on level, then on vector
	AST_BEST: assert property (
		@(posedge mclk) disable iff (!nrst)
		t_vld[0] |-> !better_seen)
		else $error("winner outranked by a pending request");

	AST_LOWSW_LAST: assert property (
		@(posedge mclk) disable iff (!nrst)
		(t_vld[0] && t_vec[0] == `VPIU_VEC_LOWSW) |-> others == '0)
		else $error("low request granted over another");

	AST_CORE_FIXED: assert property (
		@(posedge mclk) disable iff (!nrst)
		rank[`VPIU_CORE_LO] == `VPIU_RANK_L3 &&
		rank[`VPIU_CORE_HI] == `VPIU_RANK_L3)
		else $error("core exception rank wrong");

	// debug level 0 is not allowed, so it reads as level 1
	AST_DBG_RANGE: assert property (
		@(posedge mclk) disable iff (!nrst)
		rank[`VPIU_DBG_LO] >= `VPIU_RANK_L1 &&
		rank[`VPIU_DBG_HI] >= `VPIU_RANK_L1)
		else $error("debug rank out of range");

	// peripheral level 3 is clamped to level 2
	AST_PER_RANGE: assert property (
		@(posedge mclk) disable iff (!nrst)
		rank[`VPIU_VEC_CLKSYN] <= `VPIU_RANK_L2 &&
		rank[`VPIU_VEC_CLKSYN] >= `VPIU_RANK_L0 &&
		rank[`VPIU_PER_HI] <= `VPIU_RANK_L2)
		else $error("peripheral rank out of range");

	AST_CONV_ERR: assert property (
		@(posedge mclk) disable iff (!nrst)
		(conv_zero_cross || conv_limit_err) |=>
		pend_r[`VPIU_VEC_CONV_ERR])
		else $error("converter error request lost");

	AST_CONV_AB: assert property (
		@(posedge mclk) disable iff (!nrst)
		(conv_a_done || conv_b_done) |=>
		(pend_r[`VPIU_VEC_CONV_A] || !$past(conv_a_done)) &&
		(pend_r[`VPIU_VEC_CONV_B] || !$past(conv_b_done)))
		else $error("conversion complete request lost");

	// a latched pulse survives until its ack
	AST_PULSE_HELD: assert property (
		@(posedge mclk) disable iff (!nrst)
		(lat_r[`VPIU_CORE_LO] && !ack_hit[`VPIU_CORE_LO]) |=>
		lat_r[`VPIU_CORE_LO] && pend_r[`VPIU_CORE_LO])
		else $error("pending request dropped without ack");

	// an ack with no fresh pulse clears the latch
	AST_ACK_CLEAR: assert property (
		@(posedge mclk) disable iff (!nrst)
		(ack_hit[`VPIU_CORE_LO] && !req_pulse[`VPIU_CORE_LO]) |=>
		!lat_r[`VPIU_CORE_LO])
		else $error("acknowledged request still latched");

	// a dropped level is withdrawn at the next edge
	AST_LEVEL_DROP: assert property (
		@(posedge mclk) disable iff (!nrst)
		(!src[`VPIU_PER_LO] && !lat_nxt[`VPIU_PER_LO]) |=>
		!pend_r[`VPIU_PER_LO])
		else $error("withdrawn level still pending");

	// the winner is recomputed and registered every cycle
	AST_REVAL: assert property (
		@(posedge mclk) disable iff (!nrst)
		(t_vld[0] && !ack_hit[t_vec[0]]) |=>
		irq_valid_r && irq_vec_r == $past(t_vec[0]))
		else $error("winner not re-evaluated");

	AST_CORE_OFFER: assert property (
		@(posedge mclk) disable iff (!nrst)
		s_core_pulse |=> s_core_offer)
		else $error("core exception not offered in time");

	AST_SMALLEST: assert property (
		@(posedge mclk) disable iff (!nrst)
		cand[`VPIU_CORE_LO] |=>
		irq_vec_r == 6'(`VPIU_CORE_LO) || $past(ack_hit[2]))
		else $error("smallest vector at top level not chosen");
endmodule

// [vpiu_core_model.sv]
module vpiu_core_model
	import vpiu_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// offered vector
	input wire logic irq_valid,
	input wire vpiu_vec_t irq_vec,
	// bench control
	input wire logic ack_en,
	input wire logic [3:0] ack_dly,
	// acceptance
	output logic irq_ack,
	output vpiu_vec_t taken_vec
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_r;
	initial irq_ack = 1'b0;
	// one-cycle ack after ack_dly offered cycles; never two in a row
	always @(negedge mclk) begin
		irq_ack <= 1'b0;
		if (!nrst || !ack_en || !irq_valid || irq_ack) begin
			wait_r <= 4'h0;
		end else if (wait_r == ack_dly) begin
			irq_ack <= 1'b1;
			taken_vec <= irq_vec;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule

// [vectored_priority_interrupt_unit_test.sv]
module vectored_priority_interrupt_unit_test;
	import vpiu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, nrst, base_wr, ack_en, irq_ack, irq_valid;
	logic [45:0] rp, rl;
	logic [3:0] conv, ack_dly;
	logic [91:0] lvl;
	logic [20:0] base, irq_addr, reset_addr, wdog_addr;
	vpiu_vec_t irq_vec, taken_vec;
	int fails, num_checks;
	vpiu_top DUT (.mclk(mclk), .nrst(nrst), .req_pulse(rp), .req_level(rl),
		.conv_a_done(conv[0]), .conv_b_done(conv[1]),
		.conv_zero_cross(conv[2]), .conv_limit_err(conv[3]),
		.level_cfg(lvl), .vector_base_register(base), .base_wr(base_wr),
		.irq_ack(irq_ack), .irq_valid(irq_valid), .irq_vec(irq_vec),
		.irq_addr(irq_addr), .reset_addr(reset_addr), .wdog_addr(wdog_addr));
	vpiu_core_model core (.mclk(mclk), .nrst(nrst), .irq_valid(irq_valid),
		.irq_vec(irq_vec), .ack_en(ack_en), .ack_dly(ack_dly),
		.irq_ack(irq_ack), .taken_vec(taken_vec));
	task chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// check the offer, then let the core take it
	task automatic win(input int v);
		int n;
		repeat (2) @(negedge mclk);
		chk(irq_valid, 1);
		chk(irq_vec, v);
		chk(irq_addr, base + 2 * v);
		ack_en <= 1'b1;
		for (n = 0; n < 20 && irq_ack !== 1'b1; n++) @(posedge mclk);
		chk(taken_vec, v);
		@(negedge mclk) ack_en <= 1'b0;
	endtask
	task t_reset;
		chk(irq_valid, 0);
		chk(reset_addr, 0);
		chk(wdog_addr, 2);
		$display("t_reset done");
	endtask
	task t_order;
		ack_dly = 4'h3;
		lvl[33:32] = 2'h2;
		rl[16] = 1'b1;
		rp[2] = 1'b1;
		@(negedge mclk) rp[2] = 1'b0;
		win(2);
		win(16);
		rl[16] = 1'b0;
		ack_dly = 4'h0;
		$display("t_order done");
	endtask
	task t_same;
		lvl[37:36] = 2'h1;
		lvl[41:40] = 2'h1;
		rl[13] = 1'b1;
		rl[18] = 1'b1;
		rl[20] = 1'b1;
		rl[45] = 1'b1;
		win(18);
		rl[18] = 1'b0;
		win(20);
		rl[20] = 1'b0;
		win(13);
		rl[13] = 1'b0;
		win(45);
		rl[45] = 1'b0;
		$display("t_same done");
	endtask
	// debug level 0 reads as 1, so a level 2 peripheral must win
	task t_dbg;
		lvl[35:34] = 2'h2;
		rl[8] = 1'b1;
		rl[17] = 1'b1;
		win(17);
		rl[17] = 1'b0;
		win(8);
		rl[8] = 1'b0;
		$display("t_dbg done");
	endtask
	task t_conv;
		for (int i = 0; i < 4; i++) begin
			conv = 4'h1 << i;
			win(i < 2 ? 40 + i : 42);
			conv = 4'h0;
		end
		$display("t_conv done");
	endtask
	task t_rsv;
		rl = 46'h0060020C003;
		rl[25] = 1'b1;
		win(25);
		rl[25] = 1'b0;
		repeat (2) @(negedge mclk);
		chk(irq_valid, 0);
		rl = '0;
		$display("t_rsv done");
	endtask
	// base only loads while base_wr is high
	task t_base;
		base = 21'h012340;
		base_wr = 1'b1;
		@(negedge mclk) base_wr = 1'b0;
		base = 21'h1FFFFF;
		@(negedge mclk);
		chk(reset_addr, 21'h012340);
		chk(wdog_addr, 21'h012342);
		base = 21'h012340;
		rp[5] = 1'b1;
		@(negedge mclk) rp[5] = 1'b0;
		win(5);
		$display("t_base done");
	endtask
	// clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// stimulus, off the falling edge
	initial begin
		{nrst, base_wr, ack_en, rp, rl, conv, ack_dly, lvl, base} = '0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		t_reset;
		t_order;
		t_same;
		t_dbg;
		t_conv;
		t_rsv;
		t_base;
		end_sim;
	end
	// watchdog, far beyond the fewer than one hundred cycles needed
	initial begin
		#400000;
		fails++;
		end_sim;
	end
endmodule
